// *** rtl/sad_decoder.v ***
// address decoder, remap, arbiter, abort capture and protection unit
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "sad_defs.vh"
module sad_decoder #(
    parameter FLASH_AW = 19,
    parameter SRAM_AW = 15,
    parameter ROM_AW = 16,
    parameter BOOT_FLASH_INIT = 1'b0
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire cpu_req_i,
    input wire [31:0] cpu_addr_i,
    input wire cpu_we_i,
    input wire [1:0] cpu_size_i,
    input wire cpu_user_i,
    output wire cpu_gnt_o,
    input wire dma_req_i,
    input wire [31:0] dma_addr_i,
    input wire dma_we_i,
    input wire [1:0] dma_size_i,
    input wire dma_user_i,
    output wire dma_gnt_o,
    input wire erase_i,
    output reg acc_valid_o,
    output reg acc_master_o,
    output reg acc_we_o,
    output reg [1:0] acc_size_o,
    output reg [31:0] acc_addr_o,
    output reg flash_sel_o,
    output reg sram_sel_o,
    output reg rom_sel_o,
    output reg [7:0] ext_cs_o,
    output reg periph_sel_o,
    output reg sysc_sel_o,
    output reg abort_o,
    output wire remap_o,
    output wire boot_flash_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_HELD = 2'b10;
    reg remap;
    reg [1:0] arb_mode;
    reg last_dma;
    reg boot_flash;
    reg erase_meta;
    reg erase_sync;
    reg [1:0] pprot;
    reg [31:0] area_cfg [0:15];
    reg abort_valid;
    reg [1:0] abort_cause;
    reg abort_master;
    reg abort_we;
    reg abort_user;
    reg [1:0] abort_size;
    reg [31:0] abort_addr;
    reg [1:0] wb_state;
    reg [1:0] next_wb_state;
    reg [31:0] next_rdata;
    wire wb_req;
    wire wb_wr;
    wire sel_dma;
    wire acc_take;
    wire [31:0] a_addr;
    wire a_we;
    wire [1:0] a_size;
    wire a_user;
    wire [3:0] area;
    wire [7:0] int_reg;
    wire misalign;
    wire [15:0] area_hit;
    wire [15:0] area_viol;
    wire prot_scope;
    wire periph_viol;
    wire prot_viol;
    integer i;
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
        end
    endfunction
    function bad_align;
        input [1:0] low;
        input [1:0] size;
        begin
            case (size)
                `SAD_SIZE_HALF: bad_align = low[0];
                `SAD_SIZE_WORD: bad_align = |low;
                default: bad_align = 1'b0;
            endcase
        end
    endfunction
    function [31:0] alias_addr;
        input [31:0] addr;
        input integer aw;
        begin
            alias_addr = addr & ((32'h1 << aw) - 32'h1);
        end
    endfunction
    assign remap_o = remap;
    assign boot_flash_o = boot_flash;
    // bus arbiter between core and dma
    assign sel_dma = dma_req_i && (!cpu_req_i
        || arb_mode == `SAD_ARB_DMA
        || (arb_mode == `SAD_ARB_RR && !last_dma));
    assign cpu_gnt_o = cpu_req_i && !sel_dma;
    assign dma_gnt_o = sel_dma;
    assign acc_take = cpu_req_i || dma_req_i;
    assign a_addr = sel_dma ? dma_addr_i : cpu_addr_i;
    assign a_we = sel_dma ? dma_we_i : cpu_we_i;
    assign a_size = sel_dma ? dma_size_i : cpu_size_i;
    assign a_user = sel_dma ? dma_user_i : cpu_user_i;
    assign area = a_addr[31:28];
    assign int_reg = a_addr[27:20];
    assign misalign = bad_align(a_addr[1:0], a_size);
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_area
            sad_prot_area u_area (
                .cfg_i(area_cfg[g]),
                .addr_i(a_addr),
                .we_i(a_we),
                .user_i(a_user),
                .hit_o(area_hit[g]),
                .viol_o(area_viol[g])
            );
        end
    endgenerate
    // protection covers internal memory and peripherals only
    assign prot_scope = (area == `SAD_AREA_INT)
        || (area == `SAD_AREA_PERIPH);
    assign periph_viol = (area == `SAD_AREA_PERIPH)
        && ((a_we && pprot[0]) || (a_user && pprot[1]));
    assign prot_viol = prot_scope && ((|area_viol) || periph_viol);
    // access decode, one registered cycle after the grant
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_valid_o <= 1'b0;
            acc_master_o <= 1'b0;
            acc_we_o <= 1'b0;
            acc_size_o <= 2'h0;
            acc_addr_o <= 32'h0;
            flash_sel_o <= 1'b0;
            sram_sel_o <= 1'b0;
            rom_sel_o <= 1'b0;
            ext_cs_o <= 8'h0;
            periph_sel_o <= 1'b0;
            sysc_sel_o <= 1'b0;
            abort_o <= 1'b0;
            last_dma <= 1'b0;
        end else begin
            acc_valid_o <= 1'b0;
            flash_sel_o <= 1'b0;
            sram_sel_o <= 1'b0;
            rom_sel_o <= 1'b0;
            ext_cs_o <= 8'h0;
            periph_sel_o <= 1'b0;
            sysc_sel_o <= 1'b0;
            abort_o <= 1'b0;
            if (acc_take) begin
                last_dma <= sel_dma;
                acc_master_o <= sel_dma;
                acc_we_o <= a_we;
                acc_size_o <= a_size;
                acc_addr_o <= a_addr;
                if (misalign || prot_viol) begin
                    abort_o <= 1'b1;
                end else if (area == `SAD_AREA_INT) begin
                    acc_valid_o <= 1'b1;
                    case (int_reg)
                        `SAD_REG_BOOT: begin
                            if (remap) begin
                                sram_sel_o <= 1'b1;
                                acc_addr_o <= alias_addr(a_addr, SRAM_AW);
                            end else if (boot_flash) begin
                                flash_sel_o <= 1'b1;
                                acc_addr_o <= alias_addr(a_addr, FLASH_AW);
                            end else begin
                                rom_sel_o <= 1'b1;
                                acc_addr_o <= alias_addr(a_addr, ROM_AW);
                            end
                        end
                        `SAD_REG_FLASH: begin
                            flash_sel_o <= 1'b1;
                            acc_addr_o <= alias_addr(a_addr, FLASH_AW);
                        end
                        `SAD_REG_SRAM: begin
                            sram_sel_o <= 1'b1;
                            acc_addr_o <= alias_addr(a_addr, SRAM_AW);
                        end
                        `SAD_REG_ROM: begin
                            rom_sel_o <= 1'b1;
                            acc_addr_o <= alias_addr(a_addr, ROM_AW);
                        end
                        default: begin
                            acc_valid_o <= 1'b0;
                            abort_o <= 1'b1;
                        end
                    endcase
                end else if (area >= `SAD_AREA_EXT_LO
                        && area <= `SAD_AREA_EXT_HI) begin
                    acc_valid_o <= 1'b1;
                    ext_cs_o <= 8'h1 << (area - `SAD_AREA_EXT_LO);
                end else if (area == `SAD_AREA_PERIPH) begin
                    acc_valid_o <= 1'b1;
                    if (a_addr[31:12] == `SAD_SYSC_PAGE) begin
                        sysc_sel_o <= 1'b1;
                    end else begin
                        periph_sel_o <= 1'b1;
                    end
                end else begin
                    abort_o <= 1'b1;
                end
            end
        end
    end
    // erase pin synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            erase_meta <= 1'b0;
            erase_sync <= 1'b0;
        end else begin
            erase_meta <= erase_i;
            erase_sync <= erase_meta;
        end
    end
    // wishbone slave
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_req && wb_we_i && wb_ack_o;
    always @* begin
        case (wb_state)
            ST_IDLE: next_wb_state = wb_req ? ST_HELD : ST_IDLE;
            ST_HELD: next_wb_state = ST_IDLE;
            default: next_wb_state = ST_IDLE;
        endcase
    end
    always @* begin
        next_rdata = 32'h0;
        case (wb_adr_i)
            `SAD_ADR_REMAP: next_rdata = {31'h0, remap};
            `SAD_ADR_ARB: next_rdata = {30'h0, arb_mode};
            `SAD_ADR_ABSR: next_rdata = {22'h0, abort_cause, 2'h0,
                abort_master, abort_user, abort_we, abort_size,
                abort_valid};
            `SAD_ADR_ABAD: next_rdata = abort_addr;
            `SAD_ADR_NVCMD: next_rdata = {31'h0, boot_flash};
            `SAD_ADR_PPROT: next_rdata = {30'h0, pprot};
            default: begin
                if (wb_adr_i[7:6] == `SAD_ADR_AREA0 >> 6) begin
                    next_rdata = area_cfg[wb_adr_i[5:2]];
                end
            end
        endcase
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_state <= ST_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_state <= next_wb_state;
            wb_ack_o <= wb_req && wb_state == ST_IDLE;
            if (wb_req && wb_state == ST_IDLE) begin
                wb_dat_o <= next_rdata;
            end
        end
    end
    // control registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            remap <= 1'b0;
            arb_mode <= `SAD_ARB_CPU;
            pprot <= 2'h0;
            boot_flash <= BOOT_FLASH_INIT;
            for (i = 0; i < 16; i = i + 1) begin
                area_cfg[i] <= 32'h0;
            end
        end else begin
            if (wb_wr) begin
                case (wb_adr_i)
                    `SAD_ADR_REMAP: begin
                        if (wb_sel_i[0] && wb_dat_i[0]) begin
                            remap <= 1'b1;
                        end
                    end
                    `SAD_ADR_ARB: begin
                        if (wb_sel_i[0]) begin
                            arb_mode <= wb_dat_i[1:0];
                        end
                    end
                    `SAD_ADR_PPROT: begin
                        if (wb_sel_i[0]) begin
                            pprot <= wb_dat_i[1:0];
                        end
                    end
                    `SAD_ADR_NVCMD: begin
                        if (wb_sel_i[0] && wb_dat_i[0]) begin
                            boot_flash <= 1'b1;
                        end else if (wb_sel_i[0] && wb_dat_i[1]) begin
                            boot_flash <= 1'b0;
                        end
                    end
                    default: begin
                        if (wb_adr_i[7:6] == `SAD_ADR_AREA0 >> 6) begin
                            area_cfg[wb_adr_i[5:2]] <= merge(
                                area_cfg[wb_adr_i[5:2]], wb_dat_i,
                                wb_sel_i);
                        end
                    end
                endcase
            end
            if (erase_sync) begin
                boot_flash <= 1'b0;
            end
        end
    end
    // abort status capture; a new abort wins over a clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            abort_valid <= 1'b0;
            abort_cause <= 2'h0;
            abort_master <= 1'b0;
            abort_we <= 1'b0;
            abort_user <= 1'b0;
            abort_size <= 2'h0;
            abort_addr <= 32'h0;
        end else begin
            if (wb_wr && wb_adr_i == `SAD_ADR_ABSR && wb_sel_i[0]
                    && wb_dat_i[0]) begin
                abort_valid <= 1'b0;
            end
            if (acc_take && (misalign || prot_viol
                    || (area == `SAD_AREA_INT && int_reg > `SAD_REG_ROM)
                    || (area > `SAD_AREA_EXT_HI
                    && area != `SAD_AREA_PERIPH))) begin
                abort_valid <= 1'b1;
                abort_master <= sel_dma;
                abort_we <= a_we;
                abort_user <= a_user;
                abort_size <= a_size;
                abort_addr <= a_addr;
                abort_cause <= misalign ? `SAD_CAUSE_ALIGN
                    : prot_viol ? `SAD_CAUSE_PROT : `SAD_CAUSE_UNDEF;
            end
        end
    end
endmodule // sad_decoder

// *** rtl/sad_defs.vh ***
// constants of the system address decoder with remap and protection
`ifndef SAD_DEFS_VH
`define SAD_DEFS_VH
`define SAD_AREA_INT 4'h0
`define SAD_AREA_EXT_LO 4'h1
`define SAD_AREA_EXT_HI 4'h8
`define SAD_AREA_PERIPH 4'hf
`define SAD_REG_BOOT 8'h00
`define SAD_REG_FLASH 8'h01
`define SAD_REG_SRAM 8'h02
`define SAD_REG_ROM 8'h03
`define SAD_SYSC_PAGE 20'hfffff
`define SAD_SIZE_HALF 2'h1
`define SAD_SIZE_WORD 2'h2
`define SAD_SIZE_MAX 4'ha
`define SAD_ADR_REMAP 8'h00
`define SAD_ADR_ARB 8'h04
`define SAD_ADR_ABSR 8'h08
`define SAD_ADR_ABAD 8'h0c
`define SAD_ADR_NVCMD 8'h10
`define SAD_ADR_PPROT 8'h14
`define SAD_ADR_AREA0 8'h40
`define SAD_ARB_CPU 2'h0
`define SAD_ARB_DMA 2'h1
`define SAD_ARB_RR 2'h2
`define SAD_CAUSE_UNDEF 2'h1
`define SAD_CAUSE_ALIGN 2'h2
`define SAD_CAUSE_PROT 2'h3
`define SAD_AREA_EN_BIT 2
`define SAD_AREA_NOUSER_BIT 1
`define SAD_AREA_NOWR_BIT 0
`define SAD_AREA_SIZE_LSB 6
`endif

// *** rtl/sad_prot_area.v ***
// one protection area: hit and violation check
`timescale 1ns/10ps
`include "sad_defs.vh"
module sad_prot_area (
    input wire [31:0] cfg_i,
    input wire [31:0] addr_i,
    input wire we_i,
    input wire user_i,
    output wire hit_o,
    output wire viol_o
);
    wire [3:0] size_raw;
    wire [3:0] size_code;
    wire [9:0] care;
    wire enabled;
    assign size_raw = cfg_i[`SAD_AREA_SIZE_LSB+3:`SAD_AREA_SIZE_LSB];
    // size code 0 is 1 KB, each step doubles, capped at 1 MB
    assign size_code = (size_raw > `SAD_SIZE_MAX) ? `SAD_SIZE_MAX : size_raw;
    assign care = 10'h3ff << size_code;
    assign enabled = cfg_i[`SAD_AREA_EN_BIT];
    assign hit_o = enabled && (addr_i[31:20] == cfg_i[31:20])
        && ((addr_i[19:10] & care) == (cfg_i[19:10] & care));
    assign viol_o = hit_o && ((we_i && cfg_i[`SAD_AREA_NOWR_BIT])
        || (user_i && cfg_i[`SAD_AREA_NOUSER_BIT]));
endmodule // sad_prot_area

// *** dv/sad_decoder_monitor.sv ***
// port checker of the system address decoder
`timescale 1ns/10ps
module sad_decoder_monitor #(
    parameter SRAM_AW = 15
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire cpu_req_i,
    input wire [31:0] cpu_addr_i,
    input wire cpu_we_i,
    input wire [1:0] cpu_size_i,
    input wire cpu_user_i,
    input wire cpu_gnt_o,
    input wire dma_req_i,
    input wire [31:0] dma_addr_i,
    input wire dma_we_i,
    input wire [1:0] dma_size_i,
    input wire dma_user_i,
    input wire dma_gnt_o,
    input wire erase_i,
    input wire acc_valid_o,
    input wire [31:0] acc_addr_o,
    input wire flash_sel_o,
    input wire sram_sel_o,
    input wire rom_sel_o,
    input wire [7:0] ext_cs_o,
    input wire periph_sel_o,
    input wire sysc_sel_o,
    input wire abort_o,
    input wire remap_o,
    input wire boot_flash_o
);
    wire g_any = cpu_gnt_o | dma_gnt_o;
    wire [31:0] ga = cpu_gnt_o ? cpu_addr_i : dma_addr_i;
    wire [1:0] gs = cpu_gnt_o ? cpu_size_i : dma_size_i;
    wire gw = cpu_gnt_o ? cpu_we_i : dma_we_i;
    wire gu = cpu_gnt_o ? cpu_user_i : dma_user_i;
    wire mis = (gs == 2'h1 && ga[0]) || (gs == 2'h2 && ga[1:0] != 2'h0);
    wire ok = g_any && !mis && gs != 2'h3;
    wire rd = ok && !gw && !gu;
    wire [3:0] ar = ga[31:28];
    wire in0 = rd && ar == 4'h0;
    wire [7:0] rg = ga[27:20];
    wire [2:0] boot_want = {remap_o, !remap_o & boot_flash_o,
                            !remap_o & !boot_flash_o};
    wire [31:0] sram_off = ga & ((32'h1 << SRAM_AW) - 32'h1);
    wire [12:0] sels = {sysc_sel_o, periph_sel_o, rom_sel_o, sram_sel_o,
                        flash_sel_o, ext_cs_o};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_pulse: assert property (s_wb_req |=> s_ack_pulse)
        else $error("register ack not a one cycle answer");
    a_grant_one: assert property ((cpu_req_i || dma_req_i) |->
        (cpu_gnt_o ^ dma_gnt_o) && (!cpu_gnt_o || cpu_req_i)
        && (!dma_gnt_o || dma_req_i))
        else $error("grant not given to exactly one requester");
    a_area_ext: assert property (ok && ar >= 4'h1 && ar <= 4'h8 |=>
        ext_cs_o == (8'h01 << ($past(ar) - 4'h1)) && !abort_o)
        else $error("external chip select wrong");
    a_area_undef: assert property (ok && ar >= 4'h9 && ar <= 4'he |=>
        abort_o && !acc_valid_o)
        else $error("unassigned area not aborted");
    a_misalign_abort: assert property (g_any && mis |=>
        abort_o && sels == 13'h0)
        else $error("misaligned access not aborted");
    a_periph_area: assert property (rd && ar == 4'hf
        && ga[31:12] != 20'hfffff |=> periph_sel_o && !abort_o)
        else $error("peripheral area not routed");
    a_sysc_page: assert property (rd && ga[31:12] == 20'hfffff |=>
        sysc_sel_o)
        else $error("system controller page not routed");
    a_flash_fixed: assert property (in0 && rg == 8'h01 |=> flash_sel_o)
        else $error("flash base not routed");
    a_sram_fixed: assert property (in0 && rg == 8'h02 |=>
        sram_sel_o && acc_addr_o == $past(sram_off))
        else $error("sram base not routed or offset wrong");
    a_rom_fixed: assert property (in0 && rg == 8'h03 |=> rom_sel_o)
        else $error("rom base not routed");
    a_boot_map: assert property (in0 && rg == 8'h00 |=>
        {sram_sel_o, flash_sel_o, rom_sel_o} == $past(boot_want))
        else $error("boot region mapped to wrong memory");
    a_erase_clear: assert property (erase_i [*3] |->
        ##[0:2] !boot_flash_o)
        else $error("erase did not clear boot bit");
endmodule // sad_decoder_monitor

// *** dv/sad_master_model.sv ***
// bus master model driving one access port of the decoder
`timescale 1ns/10ps
module sad_master_model (
    input wire clk_i,
    input wire gnt_i,
    output reg req_o,
    output reg [31:0] addr_o,
    output reg we_o,
    output reg [1:0] size_o,
    output reg user_o
);
    initial begin
        req_o = 1'b0;
        addr_o = 32'h0;
        we_o = 1'b0;
        size_o = 2'h0;
        user_o = 1'b0;
    end

    // holds the request until granted or 51 cycles have passed, then scrambles the address
    task access(input [31:0] a, input w, input [1:0] s, input u);
        integer n;
        begin
            @(posedge clk_i);
            req_o <= 1'b1;
            addr_o <= a;
            we_o <= w;
            size_o <= s;
            user_o <= u;
            n = 0;
            @(posedge clk_i);
            while (!gnt_i && n < 50) begin
                n = n + 1;
                @(posedge clk_i);
            end
            req_o <= 1'b0;
            addr_o <= ~a;
        end
    endtask
endmodule // sad_master_model

// *** dv/test_sad_decoder.sv ***
// self-checking bench of the system address decoder
`timescale 1ns/10ps
`include "sad_defs.vh"
module test_sad_decoder;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, erase_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h0;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o, cpu_addr_i, dma_addr_i, acc_addr_o;
    wire [1:0] cpu_size_i, dma_size_i, acc_size_o;
    wire [7:0] ext_cs_o;
    wire wb_ack_o, cpu_req_i, cpu_we_i, cpu_user_i, cpu_gnt_o, dma_req_i;
    wire dma_we_i, dma_user_i, dma_gnt_o, acc_valid_o, acc_master_o;
    wire acc_we_o, flash_sel_o, sram_sel_o, rom_sel_o, periph_sel_o;
    wire sysc_sel_o, abort_o, remap_o, boot_flash_o;
    wire [13:0] sels = {abort_o, sysc_sel_o, periph_sel_o, rom_sel_o,
                        sram_sel_o, flash_sel_o, ext_cs_o};
    integer n_errors = 0, checks = 0, i;
    reg [31:0] rd, a, e;
    reg [1:0] s;
    reg [13:0] o;
    reg [79:0] rows [0:14];

    always #2.5 clk_i = ~clk_i;

    sad_decoder u_sad_decoder (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req_i(cpu_req_i),
        .cpu_addr_i(cpu_addr_i), .cpu_we_i(cpu_we_i),
        .cpu_size_i(cpu_size_i), .cpu_user_i(cpu_user_i),
        .cpu_gnt_o(cpu_gnt_o), .dma_req_i(dma_req_i),
        .dma_addr_i(dma_addr_i), .dma_we_i(dma_we_i),
        .dma_size_i(dma_size_i), .dma_user_i(dma_user_i),
        .dma_gnt_o(dma_gnt_o), .erase_i(erase_i), .acc_valid_o(acc_valid_o),
        .acc_master_o(acc_master_o), .acc_we_o(acc_we_o),
        .acc_size_o(acc_size_o), .acc_addr_o(acc_addr_o),
        .flash_sel_o(flash_sel_o), .sram_sel_o(sram_sel_o),
        .rom_sel_o(rom_sel_o), .ext_cs_o(ext_cs_o),
        .periph_sel_o(periph_sel_o), .sysc_sel_o(sysc_sel_o),
        .abort_o(abort_o), .remap_o(remap_o), .boot_flash_o(boot_flash_o));
    sad_master_model u_cpu (.clk_i(clk_i), .gnt_i(cpu_gnt_o),
        .req_o(cpu_req_i), .addr_o(cpu_addr_i), .we_o(cpu_we_i),
        .size_o(cpu_size_i), .user_o(cpu_user_i));
    sad_master_model u_dma (.clk_i(clk_i), .gnt_i(dma_gnt_o),
        .req_o(dma_req_i), .addr_o(dma_addr_i), .we_o(dma_we_i),
        .size_o(dma_size_i), .user_o(dma_user_i));

    task chk(input [95:0] name, input [31:0] exp, input [31:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s: expected %h, seen %h", name, exp, got);
            end
        end
    endtask

    task wb(input w, input [7:0] ad, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= ad;
            wb_sel_i <= 4'hf;
            wb_dat_i <= d;
            n = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk_i);
            end
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task acc(input [31:0] ad, input w, input [1:0] sz, input u);
        begin
            u_cpu.access(ad, w, sz, u);
            #1;
        end
    endtask

    task arb(input [1:0] exp);
        fork
            u_cpu.access(32'h0010_0000, 1'b0, 2'h2, 1'b0);
            u_dma.access(32'h0030_0000, 1'b0, 2'h2, 1'b0);
            begin
                @(posedge clk_i);
                #1;
                chk("grant", exp, {cpu_gnt_o, dma_gnt_o});
            end
        join
    endtask

    task conclude;
        begin
            $display("checks %0d errors %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    initial begin
        #20000;
        n_errors = n_errors + 1;
        conclude;
    end

    initial begin
        // address, size, expected selects, expected access address
        rows[0] = {32'h0010_0000, 2'h2, 14'h0100, 32'h0000_0000};
        rows[1] = {32'h0020_0004, 2'h2, 14'h0200, 32'h0000_0004};
        rows[2] = {32'h0030_0008, 2'h2, 14'h0400, 32'h0000_0008};
        rows[3] = {32'h0000_0010, 2'h2, 14'h0400, 32'h0000_0010};
        rows[4] = {32'h1000_0000, 2'h2, 14'h0001, 32'h1000_0000};
        rows[5] = {32'h8fff_fffc, 2'h2, 14'h0080, 32'h8fff_fffc};
        rows[6] = {32'h4000_0002, 2'h1, 14'h0008, 32'h4000_0002};
        rows[7] = {32'h9000_0000, 2'h2, 14'h2000, 32'h0};
        rows[8] = {32'he000_0003, 2'h0, 14'h2000, 32'h0};
        rows[9] = {32'hf000_0000, 2'h2, 14'h0800, 32'hf000_0000};
        rows[10] = {32'hffff_f000, 2'h2, 14'h1000, 32'hffff_f000};
        rows[11] = {32'h0020_0002, 2'h2, 14'h2000, 32'h0};
        rows[12] = {32'h1000_0001, 2'h1, 14'h2000, 32'h0};
        rows[13] = {32'h0020_8010, 2'h2, 14'h0200, 32'h0000_0010};
        rows[14] = {32'h0050_0000, 2'h2, 14'h2000, 32'h0};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `SAD_ADR_REMAP, 32'h0);
        chk("remap reset", 32'h0, rd);
        for (i = 0; i < 15; i = i + 1) begin
            {a, s, o, e} = rows[i];
            acc(a, 1'b0, s, 1'b0);
            chk("selects", o, sels);
            if (!o[13])
                chk("acc addr", e, acc_addr_o);
            chk("acc attr", {!o[13], 2'b00, s},
                {acc_valid_o, acc_master_o, acc_we_o, acc_size_o});
        end
        wb(1'b1, `SAD_ADR_NVCMD, 32'h1);
        acc(32'h0, 1'b0, 2'h2, 1'b0);
        chk("boot flash", 14'h0100, sels);
        @(posedge clk_i);
        erase_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        erase_i <= 1'b0;
        wb(1'b0, `SAD_ADR_NVCMD, 32'h0);
        chk("boot bit", 32'h0, rd & 32'h1);
        acc(32'h0, 1'b0, 2'h2, 1'b0);
        chk("boot rom", 14'h0400, sels);
        wb(1'b1, `SAD_ADR_REMAP, 32'h1);
        acc(32'h0, 1'b0, 2'h2, 1'b0);
        chk("remapped", 14'h0200, sels);
        acc(32'h0020_0000, 1'b0, 2'h2, 1'b0);
        chk("sram base", 14'h0200, sels);
        acc(32'h0030_0000, 1'b0, 2'h2, 1'b0);
        chk("rom base", 14'h0400, sels);
        wb(1'b1, `SAD_ADR_AREA0, 32'h0020_0005);
        u_dma.access(32'h0020_0000, 1'b1, 2'h2, 1'b0);
        #1;
        chk("prot write", 14'h2000, sels);
        chk("dma attr", 2'b11, {acc_master_o, acc_we_o});
        wb(1'b0, `SAD_ADR_ABSR, 32'h0);
        chk("abort stat", 32'h0000_032d, rd);
        wb(1'b0, `SAD_ADR_ABAD, 32'h0);
        chk("abort addr", 32'h0020_0000, rd);
        wb(1'b1, `SAD_ADR_ABSR, 32'h1);
        wb(1'b0, `SAD_ADR_ABSR, 32'h0);
        chk("abort clr", 32'h0, rd & 32'h1);
        acc(32'h0020_0400, 1'b1, 2'h2, 1'b0);
        chk("past area", 14'h0200, sels);
        acc(32'h0020_0000, 1'b0, 2'h2, 1'b0);
        chk("prot read", 14'h0200, sels);
        wb(1'b1, `SAD_ADR_PPROT, 32'h2);
        acc(32'hf000_0000, 1'b0, 2'h2, 1'b1);
        chk("periph user", 14'h2000, sels);
        wb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h0, rd);
        arb(2'b10);
        wb(1'b1, `SAD_ADR_ARB, {30'h0, `SAD_ARB_DMA});
        arb(2'b01);
        wb(1'b1, `SAD_ADR_ARB, {30'h0, `SAD_ARB_RR});
        acc(32'h0030_0000, 1'b0, 2'h2, 1'b0);
        arb(2'b01);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `SAD_ADR_ARB, 32'h0);
        chk("arb reset", {30'h0, `SAD_ARB_CPU}, rd);
        chk("remap rst", 32'h0, {remap_o, boot_flash_o});
        conclude;
    end
endmodule // test_sad_decoder

bind sad_decoder sad_decoder_monitor #(.SRAM_AW(SRAM_AW)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i),
    .cpu_we_i(cpu_we_i), .cpu_size_i(cpu_size_i), .cpu_user_i(cpu_user_i),
    .cpu_gnt_o(cpu_gnt_o), .dma_req_i(dma_req_i), .dma_addr_i(dma_addr_i),
    .dma_we_i(dma_we_i), .dma_size_i(dma_size_i), .dma_user_i(dma_user_i),
    .dma_gnt_o(dma_gnt_o), .erase_i(erase_i), .acc_valid_o(acc_valid_o),
    .acc_addr_o(acc_addr_o), .flash_sel_o(flash_sel_o),
    .sram_sel_o(sram_sel_o), .rom_sel_o(rom_sel_o), .ext_cs_o(ext_cs_o),
    .periph_sel_o(periph_sel_o), .sysc_sel_o(sysc_sel_o),
    .abort_o(abort_o), .remap_o(remap_o), .boot_flash_o(boot_flash_o));
